// ---- ddi_top.sv ----
// Descriptor intake: stages descriptor bytes, commits them into a
// buffer, and hands decoded commands to the read and write masters.
// Assumes a single clock; the writer holds a write while stalled.
//
// Summary of operation
// R01: Port is 128 or 256 bits wide
// R02: Standard: source, destination, length, control words
// R03: Extended: sequence, bursts at 0xC, control 0x1C
// R04: Every byte lane writable on its own
// R05: Control MSB commits; writer sends control last
// R06: Fields staged until a one hits bit 31
// R07: Writer skips the address the mode lacks
// R08: Unused address field is ignored
// R09: Standard layout drops address bits above 32
// R10: Upper address words only in extended layout
// R11: Length gives bytes per descriptor
// R12: Length caps bytes before end of packet
// R13: Writer always programs length, max for unlimited
// R14: Sequence number extended only, kept per master
// R15: Burst counts extended only, one to 128
// R16: Burst zero selects configured maximum
// R17: Burst above 128 is limited
// R18: Stride in words times master data bytes
// R19: Stride one sequential, zero repeats, two skips
// R20: Read stride low half, write high half
// R21: Stall writes while the buffer is full
`timescale 1ns/1ps
module ddi_top #(
	parameter bit EXTENDED = 1'b1,
	parameter ddi_pkg::ddi_mode_type XFER_MODE = ddi_pkg::MODE_MM2MM,
	parameter int RD_MAX_BURST = 16,
	parameter int WR_MAX_BURST = 16,
	parameter bit RD_BURST_EN = 1'b1,
	parameter bit WR_BURST_EN = 1'b1,
	parameter bit RD_STRIDE_EN = 1'b1,
	parameter bit WR_STRIDE_EN = 1'b1,
	localparam int DW = EXTENDED ? ddi_pkg::EXT_W : ddi_pkg::STD_W, // R01
	localparam int BW = DW / ddi_pkg::LANE_W
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic desc_write,
	input wire logic [BW-1:0] desc_byteenable,
	input wire logic [DW-1:0] desc_writedata,
	output logic desc_waitrequest,
	output logic rd_cmd_valid,
	output ddi_pkg::ddi_cmd_type rd_cmd,
	input wire logic rd_cmd_ready,
	output logic wr_cmd_valid,
	output ddi_pkg::ddi_cmd_type wr_cmd,
	input wire logic wr_cmd_ready
);
	import ddi_pkg::*;

	// ==========================================================
	// Layout constants
	// Control word sits last in either layout
	localparam int CTL_OFF = EXTENDED ? OFF_CTL_EXT : OFF_CTL_STD; // R03
	localparam int GO_POS = CTL_OFF * LANE_W + GO_BIT;
	localparam int GO_LANE = GO_POS / LANE_W;
	localparam bit NEED_RD = XFER_MODE != MODE_ST2MM;
	localparam bit NEED_WR = XFER_MODE != MODE_MM2ST;
	localparam int RD_BURST_POS = (OFF_SEQ + LANE_RD_BURST) * LANE_W;
	localparam int WR_BURST_POS = (OFF_SEQ + LANE_WR_BURST) * LANE_W;
	localparam int WR_STRIDE_POS = OFF_STRIDE * LANE_W + STRIDE_WR_LSB;

	logic [EXT_W-1:0] stage_q;
	logic [EXT_W-1:0] stage_d;
	logic accept;
	logic go_hit;
	logic push;
	logic pop;
	logic wait_q;
	logic wait_d;
	logic [PTR_W-1:0] wptr_q;
	logic [PTR_W-1:0] wptr_d;
	logic [PTR_W-1:0] rptr_q;
	logic [PTR_W-1:0] rptr_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	ddi_desc_type new_desc;
	ddi_desc_type mem_out;
	ddi_disp_type st_q;
	ddi_disp_type st_d;
	logic rd_v_q;
	logic rd_v_d;
	logic wr_v_q;
	logic wr_v_d;
	ddi_cmd_type rd_c_q;
	ddi_cmd_type rd_c_d;
	ddi_cmd_type wr_c_q;
	ddi_cmd_type wr_c_d;
	ddi_cmd_type rd_next;
	ddi_cmd_type wr_next;
	logic [BURST_CAP_W-1:0] rd_burst_eff;
	logic [BURST_CAP_W-1:0] wr_burst_eff;
	logic slots_free;

	// ==========================================================
	// Write acceptance
	// Everything stalls on a full buffer, so no commit is dropped
	assign accept = clk_en && desc_write && !wait_q; // R21
	assign go_hit = desc_byteenable[GO_LANE] && desc_writedata[GO_POS];
	assign push = accept && go_hit; // R05

	// ==========================================================
	// Staging of descriptor bytes
	// Each enabled lane lands on its own; others keep old bytes
	always_comb begin
		stage_d = stage_q;
		for (int i = 0; i < BW; i++) begin
			if (accept && desc_byteenable[i]) begin
				stage_d[i*LANE_W +: LANE_W] =
					desc_writedata[i*LANE_W +: LANE_W]; // R04
			end
		end
	end

	// Staged bytes persist after commit, so a writer may reuse them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_q <= '0;
		end else if (clk_en) begin
			stage_q <= stage_d; // R06
		end
	end

	// ==========================================================
	// Field decode of the merged descriptor
	// Decoding stage_d lets the committing write's own bytes count
	always_comb begin
		new_desc.src[WORD_W-1:0] =
			stage_d[OFF_SRC_LO*LANE_W +: WORD_W]; // R02
		new_desc.dst[WORD_W-1:0] =
			stage_d[OFF_DST_LO*LANE_W +: WORD_W];
		new_desc.length = stage_d[OFF_LEN*LANE_W +: WORD_W]; // R11
		new_desc.control = stage_d[CTL_OFF*LANE_W +: WORD_W];
		if (EXTENDED) begin
			new_desc.src[2*WORD_W-1:WORD_W] =
				stage_d[OFF_SRC_HI*LANE_W +: WORD_W]; // R10
			new_desc.dst[2*WORD_W-1:WORD_W] =
				stage_d[OFF_DST_HI*LANE_W +: WORD_W];
			new_desc.seq = stage_d[OFF_SEQ*LANE_W +: SEQ_W]; // R03
			new_desc.rd_burst = stage_d[RD_BURST_POS +: BURST_W];
			new_desc.wr_burst = stage_d[WR_BURST_POS +: BURST_W];
			new_desc.rd_stride =
				stage_d[OFF_STRIDE*LANE_W +: STRIDE_W]; // R20
			new_desc.wr_stride = stage_d[WR_STRIDE_POS +: STRIDE_W];
		end else begin
			// Upper words do not exist; wide addresses alias low
			new_desc.src[2*WORD_W-1:WORD_W] = '0; // R09
			new_desc.dst[2*WORD_W-1:WORD_W] = '0;
			new_desc.seq = '0; // R14
			new_desc.rd_burst = '0;
			new_desc.wr_burst = '0;
			new_desc.rd_stride = STRIDE_DEF;
			new_desc.wr_stride = STRIDE_DEF;
		end
	end

	// ==========================================================
	// Buffer pointers and occupancy
	always_comb begin
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		cnt_d = cnt_q;
		if (push) begin
			wptr_d = wptr_q + PTR_ONE;
		end
		if (pop) begin
			rptr_d = rptr_q + PTR_ONE;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + CNT_ONE;
		end else if (pop && !push) begin
			cnt_d = cnt_q - CNT_ONE;
		end
		// Stall is raised one cycle ahead so it can be a flop
		wait_d = cnt_d == CNT_FULL; // R21
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			wait_q <= 1'b0;
		end else if (clk_en) begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q <= cnt_d;
			wait_q <= wait_d;
		end
	end

	assign desc_waitrequest = wait_q;

	// ==========================================================
	// Descriptor buffer
	ddi_mem #(
		.W($bits(ddi_desc_type)),
		.DEPTH(DEPTH),
		.AW(PTR_W)
	) u_mem (
		.clk(clk),
		.clk_en(clk_en),
		.we(push),
		.waddr(wptr_q),
		.wdata(new_desc),
		.re(pop),
		.raddr(rptr_q),
		.rdata(mem_out)
	);

	// ==========================================================
	// Burst limiters, one per master
	ddi_burst #(
		.MAX_BURST(RD_MAX_BURST),
		.PROG_EN(RD_BURST_EN)
	) u_rd_burst (
		.prog(mem_out.rd_burst),
		.eff(rd_burst_eff)
	);

	ddi_burst #(
		.MAX_BURST(WR_MAX_BURST),
		.PROG_EN(WR_BURST_EN)
	) u_wr_burst (
		.prog(mem_out.wr_burst),
		.eff(wr_burst_eff)
	);

	// ==========================================================
	// Command build for each master
	// Stride is in words; a disabled stride walks sequentially
	always_comb begin
		rd_next.addr = mem_out.src;
		rd_next.length = mem_out.length;
		rd_next.seq = mem_out.seq; // R14
		rd_next.burst = rd_burst_eff;
		rd_next.control = mem_out.control;
		rd_next.step = RD_STRIDE_EN ?
			STEP_W'(mem_out.rd_stride) * STEP_W'(DATA_BYTES) :
			STEP_W'(DATA_BYTES); // R18
		wr_next.addr = mem_out.dst;
		wr_next.length = mem_out.length; // R12
		wr_next.seq = mem_out.seq;
		wr_next.burst = wr_burst_eff;
		wr_next.control = mem_out.control;
		wr_next.step = WR_STRIDE_EN ?
			STEP_W'(mem_out.wr_stride) * STEP_W'(DATA_BYTES) :
			STEP_W'(DATA_BYTES); // R19
	end

	// ==========================================================
	// Dispatch to the masters
	// Both slots must drain before the next descriptor is fetched
	assign slots_free = (!NEED_RD || !rd_v_q || rd_cmd_ready) &&
		(!NEED_WR || !wr_v_q || wr_cmd_ready);
	assign pop = clk_en && st_q == DS_IDLE && cnt_q != '0 && slots_free;

	always_comb begin
		st_d = st_q;
		rd_v_d = rd_v_q;
		wr_v_d = wr_v_q;
		rd_c_d = rd_c_q;
		wr_c_d = wr_c_q;
		if (rd_v_q && rd_cmd_ready) begin
			rd_v_d = 1'b0;
		end
		if (wr_v_q && wr_cmd_ready) begin
			wr_v_d = 1'b0;
		end
		case (st_q)
			DS_IDLE: begin
				if (pop) begin
					st_d = DS_LOAD;
				end
			end
			DS_LOAD: begin
				st_d = DS_IDLE;
				// A master the mode lacks never sees its address
				if (NEED_RD) begin
					rd_v_d = 1'b1; // R08
					rd_c_d = rd_next;
				end
				if (NEED_WR) begin
					wr_v_d = 1'b1; // R07
					wr_c_d = wr_next;
				end
			end
			default: begin
				st_d = DS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= DS_IDLE;
			rd_v_q <= 1'b0;
			wr_v_q <= 1'b0;
			rd_c_q <= '0;
			wr_c_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
			rd_v_q <= rd_v_d;
			wr_v_q <= wr_v_d;
			rd_c_q <= rd_c_d;
			wr_c_q <= wr_c_d;
		end
	end

	assign rd_cmd_valid = rd_v_q;
	assign rd_cmd = rd_c_q;
	assign wr_cmd_valid = wr_v_q;
	assign wr_cmd = wr_c_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_go_commits: assert property (
		push && !pop |=> cnt_q == $past(cnt_q) + CNT_ONE) // R05
		else $error("commit did not add a buffer entry");

	a_stage_only: assert property (
		accept && !go_hit && !pop |=> $stable(cnt_q)) // R06
		else $error("write without go changed buffer level");

	a_lane_alone: assert property (
		accept && desc_byteenable[0] && !desc_byteenable[1] |=>
		stage_q[LANE_W-1:0] == $past(desc_writedata[LANE_W-1:0]) &&
		$stable(stage_q[2*LANE_W-1:LANE_W])) // R04
		else $error("byte lane write leaked into neighbour");

	a_full_stall: assert property (
		cnt_q == CNT_FULL |-> desc_waitrequest && !push) // R21
		else $error("write taken while buffer full");

	a_std_high: assert property (
		rd_cmd_valid && !EXTENDED |->
		rd_cmd.addr[2*WORD_W-1:WORD_W] == '0 && rd_cmd.seq == '0) // R09
		else $error("standard layout carried upper fields");

	a_unused_master: assert property (
		XFER_MODE == MODE_MM2ST |-> !wr_cmd_valid) // R08
		else $error("unused master received a command");

	a_zero_burst: assert property (
		clk_en && st_q == DS_LOAD && NEED_RD &&
		mem_out.rd_burst == '0 |=>
		rd_cmd.burst == BURST_CAP_W'(RD_MAX_BURST)) // R16
		else $error("zero burst did not pick the maximum");

	a_big_burst: assert property (
		clk_en && st_q == DS_LOAD && NEED_RD &&
		mem_out.rd_burst > BURST_PROG_MAX |=>
		rd_cmd.burst <= BURST_PROG_MAX && rd_cmd.burst != '0) // R17
		else $error("oversized burst not limited");

	a_stride_step: assert property (
		clk_en && st_q == DS_LOAD && NEED_RD && RD_STRIDE_EN |=>
		rd_cmd.step ==
		STEP_W'($past(mem_out.rd_stride)) * STEP_W'(DATA_BYTES)) // R18
		else $error("stride step not words times width");

	a_pop_loads: assert property (
		pop |=> st_q == DS_LOAD ##1 (rd_cmd_valid || !NEED_RD)) // R05
		else $error("fetched descriptor not handed over");

	c_commit: cover property (push);
	c_full: cover property (cnt_q == CNT_FULL && desc_write);
	c_both: cover property (rd_cmd_valid && wr_cmd_valid);

endmodule

// ---- ddi_pkg.sv ----
// Constants, field layout and carrier types for the descriptor intake.
// Assumes one system clock; every file of the block but the buffer storage imports this package.
package ddi_pkg;

	// ==========================================================
	// Port widths
	localparam int STD_W = 128;
	localparam int EXT_W = 256;
	localparam int LANE_W = 8;
	localparam int WORD_W = 32;

	// ==========================================================
	// Byte offsets of the descriptor fields
	localparam int OFF_SRC_LO = 32'h0;
	localparam int OFF_DST_LO = 32'h4;
	localparam int OFF_LEN = 32'h8;
	localparam int OFF_CTL_STD = 32'hc;
	localparam int OFF_SEQ = 32'hc;
	localparam int OFF_STRIDE = 32'h10;
	localparam int OFF_SRC_HI = 32'h14;
	localparam int OFF_DST_HI = 32'h18;
	localparam int OFF_CTL_EXT = 32'h1c;

	// ==========================================================
	// Field positions and sizes
	localparam int GO_BIT = 31;
	localparam int SEQ_W = 16;
	localparam int BURST_W = 8;
	localparam int LANE_RD_BURST = 2;
	localparam int LANE_WR_BURST = 3;
	localparam int STRIDE_W = 16;
	localparam int STRIDE_WR_LSB = 16;
	localparam logic [15:0] STRIDE_DEF = 16'h0001;

	// ==========================================================
	// Burst, step and buffer sizing
	localparam int BURST_PROG_MAX = 128;
	localparam int BURST_CAP_W = 11;
	localparam int DATA_BYTES = 4;
	localparam int STEP_W = 24;
	localparam int DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;

	// ==========================================================
	// Types
	typedef enum {MODE_MM2MM, MODE_MM2ST, MODE_ST2MM} ddi_mode_type;
	typedef enum {DS_IDLE, DS_LOAD} ddi_disp_type;

	typedef struct packed {
		logic [63:0] src;
		logic [63:0] dst;
		logic [31:0] length;
		logic [15:0] seq;
		logic [7:0] rd_burst;
		logic [7:0] wr_burst;
		logic [15:0] rd_stride;
		logic [15:0] wr_stride;
		logic [31:0] control;
	} ddi_desc_type;

	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] length;
		logic [15:0] seq;
		logic [10:0] burst;
		logic [23:0] step;
		logic [31:0] control;
	} ddi_cmd_type;

endpackage

// ---- ddi_mem.sv ----
// Descriptor buffer storage: one write port, one registered read port.
// Assumes the caller never reads and writes the same empty slot at once.
`timescale 1ns/1ps
module ddi_mem #(
	parameter int W = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
)(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] rdata_q;

	// ==========================================================
	// Storage
	// No reset on the array: contents only matter once pushed
	always_ff @(posedge clk) begin
		if (clk_en && we) begin
			mem_q[waddr] <= wdata;
		end
		if (clk_en && re) begin
			rdata_q <= mem_q[raddr];
		end
	end

	assign rdata = rdata_q;

endmodule

// ---- ddi_burst.sv ----
// Per-master burst count limiter, purely combinational.
// Assumes MAX_BURST lies between 1 and 1024.
`timescale 1ns/1ps
module ddi_burst #(
	parameter int MAX_BURST = 16,
	parameter bit PROG_EN = 1'b1
)(
	input wire logic [ddi_pkg::BURST_W-1:0] prog,
	output logic [ddi_pkg::BURST_CAP_W-1:0] eff
);
	import ddi_pkg::*;

	localparam int CAP = MAX_BURST < BURST_PROG_MAX ?
		MAX_BURST : BURST_PROG_MAX;
	localparam logic [BURST_CAP_W-1:0] MAX_C = BURST_CAP_W'(MAX_BURST);
	localparam logic [BURST_CAP_W-1:0] CAP_C = BURST_CAP_W'(CAP);

	// ==========================================================
	// Limit
	// Zero or a disabled feature picks the instantiation maximum
	always_comb begin
		if (!PROG_EN || prog == '0) begin
			eff = MAX_C; // R16
		end else if (BURST_CAP_W'(prog) > CAP_C) begin
			eff = CAP_C; // R17
		end else begin
			eff = BURST_CAP_W'(prog); // R15
		end
	end

endmodule

// ---- ddi_host_model.sv ----
// Host-side writer model for the descriptor port.
// Assumes clk is the device clock; requests move on its falling edge.
`timescale 1ns/1ps
module ddi_host_model (
	input wire logic clk,
	input wire logic desc_waitrequest,
	output logic desc_write,
	output logic [31:0] desc_byteenable,
	output logic [255:0] desc_writedata
);
	import ddi_pkg::*;
	int n_stalls;

	// ==========================================================
	// Idle port
	initial begin
		desc_write = 1'b0;
		desc_byteenable = 32'h0;
		desc_writedata = 256'h0;
		n_stalls = 0;
	end

	// ==========================================================
	// One write, held unchanged through every stall cycle
	task automatic put(input logic [255:0] img, input logic [31:0] be);
		@(negedge clk);
		desc_write = 1'b1;
		desc_byteenable = be;
		desc_writedata = img;
		// Wait is registered, so its value here holds at the next edge
		while (desc_waitrequest === 1'b1) begin
			n_stalls++;
			@(negedge clk);
		end
		@(negedge clk);
		desc_write = 1'b0;
		desc_byteenable = 32'h0;
		// Released data shows no stale image
		desc_writedata = ~img;
	endtask
endmodule

// ---- test_dma_descriptor_intake.sv ----
// Self-checking bench for the descriptor intake, extended layout.
// Assumes the host writer model drives the descriptor port.
`timescale 1ns/1ps
module test_dma_descriptor_intake;
	import ddi_pkg::*;
	localparam int MAXB = 16;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic desc_write;
	logic [31:0] desc_byteenable;
	logic [255:0] desc_writedata;
	logic desc_waitrequest;
	logic rd_cmd_valid;
	logic wr_cmd_valid;
	logic rd_cmd_ready = 1'b0;
	logic wr_cmd_ready = 1'b0;
	ddi_cmd_type rd_cmd;
	ddi_cmd_type wr_cmd;
	ddi_cmd_type rd_q[$];
	ddi_cmd_type wr_q[$];
	logic [31:0] lfsr = 32'h8370e02a;
	logic [7:0] cyc = 8'h0;
	logic [7:0] bursts[8] = '{8'h0, 8'h1, 8'hf, 8'h10, 8'h11, 8'h80,
		8'h81, 8'hff};
	bit hold = 1'b0;
	int n_errors = 0;
	int n_compared = 0;
	ddi_desc_type d;

	// ==========================================================
	// Clock, design and writer
	always #12.5 clk = ~clk;

	ddi_top #(.EXTENDED(1'b1), .XFER_MODE(MODE_MM2MM),
		.RD_MAX_BURST(MAXB), .WR_MAX_BURST(MAXB)) ddi_top_inst (
		.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.desc_write(desc_write), .desc_byteenable(desc_byteenable),
		.desc_writedata(desc_writedata),
		.desc_waitrequest(desc_waitrequest),
		.rd_cmd_valid(rd_cmd_valid), .rd_cmd(rd_cmd),
		.rd_cmd_ready(rd_cmd_ready), .wr_cmd_valid(wr_cmd_valid),
		.wr_cmd(wr_cmd), .wr_cmd_ready(wr_cmd_ready));

	ddi_host_model ddi_host_model_inst (
		.clk(clk), .desc_waitrequest(desc_waitrequest),
		.desc_write(desc_write), .desc_byteenable(desc_byteenable),
		.desc_writedata(desc_writedata));

	// ==========================================================
	// Expectations
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
		return lfsr;
	endfunction

	function automatic ddi_cmd_type exp_cmd(ddi_desc_type x, bit rd);
		ddi_cmd_type c;
		logic [7:0] b;
		b = rd ? x.rd_burst : x.wr_burst;
		c.addr = rd ? x.src : x.dst;
		c.length = x.length;
		c.seq = x.seq;
		// Zero or oversize counts fall back to the master's maximum
		c.burst = (b == 8'h0 || b > MAXB) ? 11'(MAXB) : 11'(b);
		c.step = 24'(rd ? x.rd_stride : x.wr_stride) * 24'(DATA_BYTES);
		c.control = x.control;
		return c;
	endfunction

	function automatic logic [255:0] image(ddi_desc_type x);
		return {x.control, x.dst[63:32], x.src[63:32], x.wr_stride,
			x.rd_stride, x.wr_burst, x.rd_burst, x.seq, x.length,
			x.dst[31:0], x.src[31:0]};
	endfunction

	task automatic expect_both(ddi_desc_type x);
		rd_q.push_back(exp_cmd(x, 1'b1));
		wr_q.push_back(exp_cmd(x, 1'b0));
	endtask

	// Each word goes in two writes split at a random lane
	task automatic send(ddi_desc_type x);
		logic [31:0] lo;
		int k;
		for (int w = 0; w < 8; w++) begin
			k = 1 + int'(rnd() % 3);
			lo = ((32'h1 << k) - 32'h1) << (4 * w);
			ddi_host_model_inst.put(image(x), lo);
			ddi_host_model_inst.put(image(x), (32'hf << (4 * w)) & ~lo);
		end
		expect_both(x);
	endtask

	// ==========================================================
	// Comparison and reporting
	task automatic cmp(logic [31:0] got, logic [31:0] e);
		n_compared++;
		if (got !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic check(ddi_cmd_type got, ref ddi_cmd_type q[$]);
		ddi_cmd_type e;
		e = '0;
		if (q.size() > 0)
			e = q.pop_front();
		n_compared++;
		if (got !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic drain();
		int t;
		t = 0;
		while (rd_q.size() + wr_q.size() > 0 && t < 400) begin
			@(negedge clk);
			t++;
		end
		cmp(32'(rd_q.size() + wr_q.size()), 32'h0);
	endtask

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Commands are checked at the edge that takes them
	always @(posedge clk) begin
		if (rd_cmd_valid === 1'b1 && rd_cmd_ready === 1'b1)
			check(rd_cmd, rd_q);
		if (wr_cmd_valid === 1'b1 && wr_cmd_ready === 1'b1)
			check(wr_cmd, wr_q);
	end

	// Ready pattern with stalls; hold freezes both masters
	always @(negedge clk) begin
		cyc <= cyc + 8'h1;
		rd_cmd_ready <= !hold && (cyc % 3 != 0);
		wr_cmd_ready <= !hold && cyc[1];
	end

	// Watchdog sized well above the expected run
	initial begin
		#(25 * 20000);
		cmp(32'h1, 32'h0);
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		// Random descriptors with corner burst and stride values
		for (int i = 0; i < 24; i++) begin
			d.src = {rnd(), rnd()};
			d.dst = {rnd(), rnd()};
			d.length = (i == 0) ? 32'hfffffff : rnd();
			d.seq = 16'(rnd());
			d.rd_burst = bursts[i % 8];
			d.wr_burst = bursts[(i + 3) % 8];
			d.rd_stride = (i < 3) ? 16'(i) : 16'(rnd());
			d.wr_stride = (i < 3) ? 16'(2 - i) : 16'(rnd());
			d.control = {1'b1, 31'(rnd())};
			send(d);
		end
		drain();
		$display("test random_descriptors done");
		// All lanes staged with go low: nothing may leave
		d.control = 32'h0000_0012;
		ddi_host_model_inst.put(image(d), 32'hffff_ffff);
		repeat (8) begin
			@(negedge clk);
			cmp(32'({rd_cmd_valid, wr_cmd_valid}), 32'h0);
		end
		d.control = 32'h8000_0034;
		ddi_host_model_inst.put(image(d), 32'hf000_0000);
		expect_both(d);
		// Enable low: the fresh commit must not move toward the masters
		clk_en = 1'b0;
		repeat (6) begin
			@(negedge clk);
			cmp(32'({rd_cmd_valid, wr_cmd_valid}), 32'h0);
		end
		clk_en = 1'b1;
		drain();
		$display("test staged_commit done");
		// Commits pile up while both masters stall
		hold = 1'b1;
		for (int i = 0; i < 10; i++) begin
			if (i == 9) begin
				@(negedge clk);
				cmp(32'(desc_waitrequest), 32'h1);
				fork
					begin
						repeat (30) @(negedge clk);
						hold = 1'b0;
					end
				join_none
			end
			d.control = 32'h8000_0000 | i;
			ddi_host_model_inst.put(image(d), 32'hf000_0000);
			expect_both(d);
		end
		cmp(32'(ddi_host_model_inst.n_stalls > 0), 32'h1);
		drain();
		$display("test full_buffer done");
		report_and_stop();
	end
endmodule
